// [rtl/dcrl_map.vh]
// Constants for the reset and configuration loader of the disk controller.
// Assumes a 10 MHz clk_i and a classic Wishbone slave with 32-bit data.
// Functional notes
// [RULE1] Bus address from jumpers, fitted reads one
// [RULE2] Third jumper is MSB, first is LSB
// [RULE3] Half-rate jumper: single-sector at system clock/4
// [RULE4] Multisector always at data clock/2; the code passes only the data clock ticks that land on alternate system clocks
// [RULE5] Diagnostic jumper: reset runs continuous self-test
// [RULE6] Precomp jumper: reduced-current cylinder, all, or none
// [RULE7] One precomp setting serves both drives
// [RULE8] Power-up: wait 40 s for ready, record drives
// [RULE9] Bus reset: same sequence, 200 ms wait
// [RULE10] Recalibrate head to outermost track if needed
// [RULE11] Already at outermost: step off, seek back
// [RULE12] Read stored parameters from track zero, head zero
// [RULE13] Parameters absent: set format-invalid, finish sequence
// [RULE14] Formatted: seek last cylinder, save last block
// [RULE15] Return outward, store per-zone defect counts
// [RULE16] Run self-diagnostics after power-up
// [RULE17] Unavailable about one second after hardware reset
// [RULE18] Invalid format: first command fails, except three
// [RULE19] Format-invalid sense leaves address-valid bit clear
// [RULE20] Invalid format refuses media access, code 1C
// [RULE21] Read/write retries recovery before reporting 1C
// [RULE22] Host resets only at power-up or recovery
// [RULE23] Host: test ready until 00, mode select, format
// [RULE24] Format writes mode-select parameters to disk; code only stores a word written to the parameter register
// [RULE25] Bus reset aborts, releases bus, reloads parameters
// [RULE26] Bus reset as short as 50 ns accepted; the pin is only sampled each clock, so pulses under one clock may be missed
// [RULE27] Reset mid-sequence restarts, discards partial load
// [RULE28] Format-invalid flag per drive, cleared on valid load
`ifndef DCRL_MAP_VH
`define DCRL_MAP_VH
`define DCRL_CLK_HZ        10000000
`define DCRL_PWR_WAIT_MS   40000
`define DCRL_BRST_WAIT_MS  200
`define DCRL_BUSY_MS       1000
`define DCRL_ERR_FMT       8'h1C
`define DCRL_OP_TUR        8'h00
`define DCRL_OP_SENSE      8'h03
`define DCRL_OP_MODESEL    8'h15
`define DCRL_OP_FORMAT     8'h04
`define DCRL_OP_READ       8'h08
`define DCRL_OP_WRITE      8'h0A
`define DCRL_OP_SEEK       8'h0B
`define DCRL_OP_REZERO     8'h01
`define DCRL_REG_CTRL      8'h00
`define DCRL_REG_STAT      8'h04
`define DCRL_REG_JMP       8'h08
`define DCRL_REG_CMD       8'h0C
`define DCRL_REG_RESP      8'h10
`define DCRL_REG_LASTBLK   8'h14
`define DCRL_REG_DEFECT    8'h18
`define DCRL_REG_PARAM     8'h1C
`define DCRL_CTRL_BRST     0
`endif

// [rtl/dcrl_loader.v]
// Reset sequencer, jumper decoder and format lockout of the disk controller.
// Drive mechanics are plain ports; software reaches the tables over Wishbone.
//
// Chosen here: the placing of the registers and the Wishbone slave port.
`include "dcrl_map.vh"
module dcrl_loader #(
  parameter integer PWR_WAIT_CYC  = (`DCRL_CLK_HZ / 1000) * `DCRL_PWR_WAIT_MS,
  parameter integer BRST_WAIT_CYC = (`DCRL_CLK_HZ / 1000) * `DCRL_BRST_WAIT_MS,
  parameter integer BUSY_CYC      = (`DCRL_CLK_HZ / 1000) * `DCRL_BUSY_MS
) (
  input  wire        clk_i,              // System clock, 10 MHz
  input  wire        rst_i,              // Sync reset, power-up
  input  wire        bus_rst_n_i,        // Bus reset pin, low true
  input  wire [2:0]  addr_jmp_i,         // Address jumpers, 1 = fitted
  input  wire        half_rate_jmp_i,    // Half-rate jumper fitted
  input  wire        diag_jmp_i,         // Diagnostic jumper fitted
  input  wire        pcomp_rwc_jmp_i,    // Precomp from reduced-current cyl
  input  wire        pcomp_all_jmp_i,    // Precomp on all tracks
  input  wire        data_clk_en_i,      // Data clock tick, one cycle
  input  wire        multi_sector_i,     // Transfer is multisector
  input  wire [1:0]  drv_ready_i,        // Drive ready pins
  input  wire [1:0]  drv_trk0_i,         // Track zero pins
  input  wire        seek_done_i,        // Seek/step complete pulse
  input  wire        seek_err_i,         // Seek failed pulse
  input  wire        rd_done_i,          // Media read complete pulse
  input  wire        rd_ok_i,            // Read data valid (with done)
  input  wire [31:0] rd_data_i,          // Word read from media
  input  wire        diag_pass_i,        // Self-test result (with done)
  input  wire        diag_done_i,        // Self-test complete pulse
  input  wire        wb_cyc_i,           // Wishbone cycle
  input  wire        wb_stb_i,           // Wishbone strobe
  input  wire        wb_we_i,            // Wishbone write
  input  wire [7:0]  wb_adr_i,           // Wishbone byte address
  input  wire [3:0]  wb_sel_i,           // Wishbone byte selects
  input  wire [31:0] wb_dat_i,           // Wishbone write data
  output reg  [31:0] wb_dat_o,           // Wishbone read data
  output wire        wb_ack_o,           // Wishbone acknowledge
  output reg  [2:0]  scsi_id_o,          // Bus address
  output reg         xfer_en_o,          // DMA transfer tick
  output reg  [1:0]  pcomp_mode_o,       // 0 none, 1 from rwc, 2 all
  output reg         bus_release_o,      // Drop off the bus
  output reg  [1:0]  drv_present_o,      // Drives found attached
  output reg  [1:0]  fmt_invalid_o,      // Per-drive format invalid
  output reg         busy_o,             // Not available to host
  output reg         drv_sel_o,          // Drive under sequence
  output reg         seek_req_o,         // Seek request pulse
  output reg  [1:0]  seek_kind_o,        // 0 recal,1 step off,2 last,3 zone
  output reg  [1:0]  seek_zone_o,        // Zone for zone seeks
  output reg         rd_req_o,           // Media read request pulse
  output reg         rd_kind_o,          // 0 parameters, 1 last block / count
  output reg         diag_req_o          // Self-test request pulse
);
  localparam [3:0] S_IDLE = 4'h0, S_WAIT = 4'h1, S_DIAG = 4'h2, S_RECAL = 4'h3,
                   S_STEP = 4'h4, S_BACK = 4'h5, S_PARM = 4'h6, S_LAST = 4'h7,
                   S_LRD  = 4'h8, S_ZONE = 4'h9, S_ZRD  = 4'hA, S_NEXT = 4'hB,
                   S_LOOP = 4'hC, S_DONE = 4'hD;

  reg  [3:0]  st_q;
  reg  [31:0] wait_q;
  reg  [31:0] busy_q;
  reg         pending_q;
  reg         issued_q;
  reg  [1:0]  zone_q;
  reg         diag_fail_q;
  reg  [31:0] param_q   [0:1];
  reg  [31:0] lastblk_q [0:1];
  reg  [15:0] defect_q  [0:7];
  reg  [1:0]  brst_sync_q;
  reg         brst_lat_q;
  reg  [6:0]  jmp_s1_q;
  reg  [6:0]  jmp_s2_q;
  reg  [1:0]  rdy_s1_q;
  reg  [1:0]  rdy_s2_q;
  reg  [1:0]  trk0_s1_q;
  reg  [1:0]  trk0_s2_q;
  reg  [1:0]  div_q;
  reg  [7:0]  cmd_q;
  reg         cmd_drv_q;
  reg  [7:0]  resp_q;
  reg         first_cmd_q;
  reg         ack_q;
  reg         brst_soft;
  reg         restore_q;
  reg         restore_drv_q;

  wire wb_req  = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wb_wr   = wb_req & wb_we_i & wb_sel_i[0];
  wire brst_ev = brst_lat_q | brst_soft;
  assign wb_ack_o = ack_q;

  function media_op;
    input [7:0] op;
    begin
      media_op = (op == `DCRL_OP_READ) | (op == `DCRL_OP_WRITE) |
                 (op == `DCRL_OP_SEEK) | (op == `DCRL_OP_REZERO);
    end
  endfunction

  function exempt_op;
    input [7:0] op;
    begin
      exempt_op = (op == `DCRL_OP_SENSE) | (op == `DCRL_OP_TUR) |
                  (op == `DCRL_OP_MODESEL);
    end
  endfunction

  // Pin must stand for one clock sample; shorter pulses may be missed
  always @(posedge clk_i) begin
    if (rst_i) begin
      brst_sync_q <= 2'b00;
      brst_lat_q  <= 1'b0;
    end else begin
      brst_sync_q <= {brst_sync_q[0], ~bus_rst_n_i};                        // [RULE26]
      brst_lat_q  <= brst_sync_q[1] & ~brst_lat_q;
    end
  end

  always @(posedge clk_i) begin
    jmp_s1_q    <= {pcomp_all_jmp_i, pcomp_rwc_jmp_i, diag_jmp_i, half_rate_jmp_i, addr_jmp_i};
    jmp_s2_q    <= jmp_s1_q;
    rdy_s1_q    <= drv_ready_i;
    rdy_s2_q    <= rdy_s1_q;
    trk0_s1_q   <= drv_trk0_i;
    trk0_s2_q   <= trk0_s1_q;
  end

  // Jumper decode and transfer clocking
  always @(posedge clk_i) begin
    if (rst_i) begin
      scsi_id_o    <= 3'h0;
      pcomp_mode_o <= 2'h0;
      div_q        <= 2'h0;
      xfer_en_o    <= 1'b0;
    end else begin
      scsi_id_o    <= jmp_s2_q[2:0];                                      // [RULE1] [RULE2]
      pcomp_mode_o <= jmp_s2_q[6] ? 2'h2 : (jmp_s2_q[5] ? 2'h1 : 2'h0);   // [RULE6] [RULE7]
      div_q        <= div_q + 2'h1;
      if (multi_sector_i)
        xfer_en_o <= data_clk_en_i & ~div_q[0];                           // [RULE4]
      else if (jmp_s2_q[3])
        xfer_en_o <= (div_q == 2'h3);                                     // [RULE3]
      else
        xfer_en_o <= div_q[0];
    end
  end

  // Initialisation sequencer
  always @(posedge clk_i) begin
    seek_req_o <= 1'b0;
    rd_req_o   <= 1'b0;
    diag_req_o <= 1'b0;
    if (rst_i) begin
      st_q          <= S_WAIT;
      wait_q        <= PWR_WAIT_CYC;                                      // [RULE8]
      busy_q        <= BUSY_CYC;
      busy_o        <= 1'b1;
      pending_q     <= 1'b1;
      issued_q      <= 1'b0;
      zone_q        <= 2'h0;
      diag_fail_q   <= 1'b0;
      drv_present_o <= 2'h0;
      fmt_invalid_o <= 2'h0;
      drv_sel_o     <= 1'b0;
      bus_release_o <= 1'b1;
      seek_kind_o   <= 2'h0;
      seek_zone_o   <= 2'h0;
      rd_kind_o     <= 1'b0;
    end else if (brst_ev) begin
      st_q          <= S_WAIT;                                            // [RULE25] [RULE27]
      wait_q        <= BRST_WAIT_CYC;                                     // [RULE9]
      busy_q        <= BUSY_CYC;
      busy_o        <= 1'b1;
      bus_release_o <= 1'b1;
      pending_q     <= 1'b1;
      issued_q      <= 1'b0;
      drv_present_o <= 2'h0;
      fmt_invalid_o <= 2'h0;
      drv_sel_o     <= 1'b0;
    end else begin
      if (busy_q != 32'h0)
        busy_q <= busy_q - 32'h1;
      case (st_q)
        S_IDLE: begin
          busy_o        <= (busy_q != 32'h0);                             // [RULE17]
          bus_release_o <= 1'b0;
          // Pending low marks a finished recovery awaiting its response
          if (restore_q & pending_q) begin                                // [RULE21]
            drv_sel_o <= restore_drv_q;
            st_q      <= S_RECAL;
            issued_q  <= 1'b0;
            pending_q <= 1'b0;
          end else if (!restore_q) begin
            pending_q <= 1'b1;
            if (jmp_s2_q[4])
              st_q <= S_WAIT;                                             // [RULE5]
          end
        end
        S_WAIT: begin
          if ((rdy_s2_q == 2'h3) || (wait_q == 32'h0)) begin
            drv_present_o <= rdy_s2_q;                                    // [RULE8]
            st_q          <= S_DIAG;
            issued_q      <= 1'b0;
          end else begin
            wait_q <= wait_q - 32'h1;
          end
        end
        S_DIAG: begin
          if (!issued_q) begin
            diag_req_o <= 1'b1;                                           // [RULE16]
            issued_q   <= 1'b1;
          end else if (diag_done_i) begin
            diag_fail_q <= ~diag_pass_i;
            issued_q    <= 1'b0;
            drv_sel_o   <= drv_present_o[0] ? 1'b0 : 1'b1;
            st_q        <= (drv_present_o == 2'h0) ? S_DONE : S_RECAL;
          end
        end
        S_RECAL: begin
          if (!issued_q) begin
            seek_req_o  <= 1'b1;
            seek_kind_o <= trk0_s2_q[drv_sel_o] ? 2'h1 : 2'h0;            // [RULE10] [RULE11]
            issued_q    <= 1'b1;
          end else if (seek_done_i | seek_err_i) begin
            issued_q <= 1'b0;
            st_q     <= seek_err_i ? S_NEXT : ((seek_kind_o == 2'h1) ? S_BACK : S_PARM);
          end
        end
        S_BACK: begin
          if (!issued_q) begin
            seek_req_o  <= 1'b1;
            seek_kind_o <= 2'h0;                                          // [RULE11]
            issued_q    <= 1'b1;
          end else if (seek_done_i | seek_err_i) begin
            issued_q <= 1'b0;
            st_q     <= seek_err_i ? S_NEXT : S_PARM;
          end
        end
        S_PARM: begin
          if (!issued_q) begin
            rd_req_o  <= 1'b1;
            rd_kind_o <= 1'b0;                                            // [RULE12]
            issued_q  <= 1'b1;
          end else if (rd_done_i) begin
            issued_q <= 1'b0;
            if (rd_ok_i) begin
              param_q[drv_sel_o]       <= rd_data_i;
              fmt_invalid_o[drv_sel_o] <= 1'b0;                           // [RULE28]
              st_q                     <= S_LAST;
            end else begin
              fmt_invalid_o[drv_sel_o] <= 1'b1;                           // [RULE13]
              st_q                     <= S_NEXT;
            end
          end
        end
        S_LAST: begin
          seek_req_o  <= 1'b1;
          seek_kind_o <= 2'h2;                                            // [RULE14]
          st_q        <= S_LRD;
        end
        S_LRD: begin
          if (!issued_q & seek_done_i) begin
            rd_req_o  <= 1'b1;
            rd_kind_o <= 1'b1;
            issued_q  <= 1'b1;
          end else if (issued_q & rd_done_i) begin
            lastblk_q[drv_sel_o] <= rd_data_i;                            // [RULE14]
            issued_q             <= 1'b0;
            zone_q               <= 2'h3;
            st_q                 <= S_ZONE;
          end
        end
        S_ZONE: begin
          seek_req_o  <= 1'b1;
          seek_kind_o <= 2'h3;                                            // [RULE15]
          seek_zone_o <= zone_q;
          st_q        <= S_ZRD;
        end
        S_ZRD: begin
          if (!issued_q & seek_done_i) begin
            rd_req_o <= 1'b1;
            issued_q <= 1'b1;
          end else if (issued_q & rd_done_i) begin
            defect_q[{drv_sel_o, zone_q}] <= rd_data_i[15:0];             // [RULE15]
            issued_q <= 1'b0;
            zone_q   <= zone_q - 2'h1;
            st_q     <= (zone_q == 2'h0) ? S_NEXT : S_ZONE;
          end
        end
        S_NEXT: begin
          if (restore_q) begin
            st_q <= S_IDLE;
          end else if (!drv_sel_o && drv_present_o[1]) begin
            drv_sel_o <= 1'b1;
            st_q      <= S_RECAL;
          end else begin
            st_q <= S_DONE;
          end
        end
        S_DONE: begin
          pending_q <= 1'b1;
          st_q      <= S_IDLE;
        end
        default: st_q <= S_IDLE;
      endcase
    end
    if (wb_wr && wb_adr_i == `DCRL_REG_PARAM)
      param_q[wb_dat_i[31]] <= {1'b0, wb_dat_i[30:0]};                    // [RULE24]
  end

  // Command screening and register bus
  always @(posedge clk_i) begin
    brst_soft <= 1'b0;
    if (rst_i) begin
      ack_q         <= 1'b0;
      cmd_q         <= 8'h00;
      cmd_drv_q     <= 1'b0;
      resp_q        <= 8'h00;
      first_cmd_q   <= 1'b1;
      restore_q     <= 1'b0;
      restore_drv_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
      if (brst_ev)
        first_cmd_q <= 1'b1;
      if (restore_q && st_q == S_IDLE && !pending_q) begin
        restore_q <= 1'b0;
        resp_q    <= fmt_invalid_o[restore_drv_q] ? `DCRL_ERR_FMT : 8'h00; // [RULE21]
      end
      if (wb_wr && wb_adr_i == `DCRL_REG_CTRL) begin
        brst_soft <= wb_dat_i[`DCRL_CTRL_BRST];
      end
      if (wb_wr && wb_adr_i == `DCRL_REG_CMD && !busy_o) begin
        cmd_q       <= wb_dat_i[7:0];
        cmd_drv_q   <= wb_dat_i[8];
        first_cmd_q <= 1'b0;
        if (fmt_invalid_o[wb_dat_i[8]] && (wb_dat_i[7:0] == `DCRL_OP_READ ||
            wb_dat_i[7:0] == `DCRL_OP_WRITE)) begin
          restore_q     <= 1'b1;                                          // [RULE21]
          restore_drv_q <= wb_dat_i[8];
          resp_q        <= 8'hFF;
        end else if (fmt_invalid_o[wb_dat_i[8]] && media_op(wb_dat_i[7:0]))
          resp_q <= `DCRL_ERR_FMT;                                        // [RULE20]
        else if (fmt_invalid_o[wb_dat_i[8]] && first_cmd_q && !exempt_op(wb_dat_i[7:0]))
          resp_q <= `DCRL_ERR_FMT;                                        // [RULE18]
        else
          resp_q <= 8'h00;
      end
    end
  end

  always @(posedge clk_i) begin
    if (rst_i)
      wb_dat_o <= 32'h0;
    else if (wb_req) begin
      case (wb_adr_i)
        `DCRL_REG_STAT:    wb_dat_o <= {24'h0, fmt_invalid_o, drv_present_o, 1'b0,
                                        diag_fail_q, jmp_s2_q[4], busy_o};
        `DCRL_REG_JMP:     wb_dat_o <= {27'h0, pcomp_mode_o, scsi_id_o};
        `DCRL_REG_CMD:     wb_dat_o <= {23'h0, cmd_drv_q, cmd_q};
        // Sense byte 0: address-valid bit kept clear for format errors
        `DCRL_REG_RESP:    wb_dat_o <= {24'h0, 1'b0, resp_q[6:0]};        // [RULE19]
        `DCRL_REG_LASTBLK: wb_dat_o <= lastblk_q[wb_sel_i[1]];
        `DCRL_REG_DEFECT:  wb_dat_o <= {16'h0, defect_q[wb_dat_i[2:0]]};
        `DCRL_REG_PARAM:   wb_dat_o <= param_q[wb_sel_i[1]];
        default:           wb_dat_o <= 32'h0;
      endcase
    end
  end
endmodule

// [testbench/dcrl_loader_assertions.sv]
// Checker for the reset loader.
// Assumes the bench holds the data clock tick high and jumpers steady between tests.
module dcrl_loader_chk (
  input wire logic       clk_i,            // System clock
  input wire logic       rst_i,            // Power-up reset
  input wire logic       bus_rst_n_i,      // Bus reset pin
  input wire logic [2:0] addr_jmp_i,       // Address jumpers
  input wire logic       half_rate_jmp_i,  // Half-rate jumper
  input wire logic       pcomp_rwc_jmp_i,  // Precomp from rwc
  input wire logic       pcomp_all_jmp_i,  // Precomp all
  input wire logic       multi_sector_i,   // Multisector
  input wire logic       wb_cyc_i,         // Wishbone cycle
  input wire logic       wb_stb_i,         // Wishbone strobe
  input wire logic       wb_ack_o,         // Wishbone ack
  input wire logic [2:0] scsi_id_o,        // Bus address
  input wire logic       xfer_en_o,        // Transfer tick
  input wire logic [1:0] pcomp_mode_o,     // Precomp mode
  input wire logic       bus_release_o,    // Off the bus
  input wire logic [1:0] drv_present_o,    // Drives found
  input wire logic       busy_o            // Busy
);
  logic [1:0] mode_q;
  logic [3:0] calm_q;
  logic       calm;
  // The half-rate jumper passes two sync flops (multisector none), so pacing is judged only once settled
  always @(posedge clk_i) begin
    mode_q <= {multi_sector_i, half_rate_jmp_i};
    if (rst_i || mode_q != {multi_sector_i, half_rate_jmp_i}) calm_q <= 4'h0;
    else if (calm_q != 4'hF) calm_q <= calm_q + 4'h1;
  end
  assign calm = calm_q > 4'h8;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_id_jumpers: assert property (
    $stable(addr_jmp_i)[*6] |-> scsi_id_o == addr_jmp_i) else $error("bus address wrong");
  chk_pcomp_sel: assert property (
    $stable({pcomp_rwc_jmp_i, pcomp_all_jmp_i})[*6] |-> pcomp_mode_o ==
    (pcomp_all_jmp_i ? 2'h2 : {1'b0, pcomp_rwc_jmp_i})) else $error("precomp mode wrong");
  chk_half_rate: assert property (
    calm && !multi_sector_i && half_rate_jmp_i && xfer_en_o |=> (!xfer_en_o || !calm)[*3]
    ##1 (xfer_en_o || !calm)) else $error("half rate pacing wrong");
  chk_full_rate: assert property (
    calm && !multi_sector_i && !half_rate_jmp_i && xfer_en_o |=> (!xfer_en_o || !calm)
    ##1 (xfer_en_o || !calm)) else $error("full rate pacing wrong");
  chk_multi_rate: assert property (
    calm && multi_sector_i && xfer_en_o |=> !xfer_en_o || !calm) else $error("multi pacing");
  chk_busy_start: assert property (
    $fell(rst_i) |-> busy_o && bus_release_o) else $error("not busy after reset");
  chk_bus_reset: assert property (
    !bus_rst_n_i[*2] |-> ##[0:5] (busy_o && bus_release_o)) else $error("bus reset missed");
  chk_ack_one: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  chk_ack_drop: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack held");
  chk_present_hold: assert property (
    !busy_o ##1 !busy_o |-> $stable(drv_present_o)) else $error("present changed idle");
  cov_idle: cover property ($fell(busy_o));
  cov_half: cover property (calm && half_rate_jmp_i && !multi_sector_i && xfer_en_o);
  cov_brst: cover property (!bus_rst_n_i[*2]);
endmodule

bind dcrl_loader dcrl_loader_chk u_dcrl_loader_chk (.*);

// [testbench/dcrl_drive_model.sv]
// Drive model: answers each request after DLY cycles.
// Assumes one request in flight; track zero follows the kind of the last seek.
module dcrl_drive_model #(
  parameter int          DLY      = 3,
  parameter logic [31:0] LAST_BLK = 32'h0000_4C2F,
  parameter logic [31:0] PARAM_W  = 32'h0000_0100
) (
  input  wire logic        clk_i,        // System clock
  input  wire logic        rst_i,        // Power-up reset
  input  wire logic        seek_req_i,   // Seek request
  input  wire logic [1:0]  seek_kind_i,  // Seek kind
  input  wire logic [1:0]  seek_zone_i,  // Zone
  input  wire logic        rd_req_i,     // Read request
  input  wire logic        rd_kind_i,    // 0 parameters
  input  wire logic        diag_req_i,   // Self-test request
  input  wire logic        drv_sel_i,    // Drive
  input  wire logic [1:0]  fmt_ok_i,     // Parameters present
  output logic             seek_done_o,  // Seek done
  output logic             rd_done_o,    // Read done
  output logic             rd_ok_o,      // Read good
  output logic [31:0]      rd_data_o,    // Read word
  output logic             diag_done_o,  // Self-test done
  output logic [1:0]       trk0_o        // On track zero
);
  logic [7:0]  cnt_q;
  logic [1:0]  op_q;
  logic        kind_q;
  logic [31:0] val_q;
  always @(posedge clk_i) begin
    seek_done_o <= 1'b0;
    rd_done_o <= 1'b0;
    diag_done_o <= 1'b0;
    rd_ok_o <= 1'b0;
    // Data is only good with done; toggling stops anyone leaning on stale words
    rd_data_o <= ~rd_data_o;
    if (rst_i) begin
      cnt_q <= 8'h00;
      trk0_o <= 2'h1;
      rd_data_o <= 32'h0;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        seek_done_o <= op_q == 2'h0;
        diag_done_o <= op_q == 2'h2;
        rd_done_o <= op_q == 2'h1;
        rd_ok_o <= op_q == 2'h1 && (kind_q || fmt_ok_i[drv_sel_i]);
        rd_data_o <= kind_q ? val_q : PARAM_W;
      end
    end else if (seek_req_i) begin
      cnt_q <= 8'(DLY);
      op_q <= 2'h0;
      trk0_o[drv_sel_i] <= seek_kind_i == 2'h0;
      val_q <= (seek_kind_i == 2'h2) ? LAST_BLK : 32'h10 + 32'(seek_zone_i);
    end else if (rd_req_i || diag_req_i) begin
      cnt_q <= 8'(DLY);
      op_q <= rd_req_i ? 2'h1 : 2'h2;
      kind_q <= rd_kind_i;
    end
  end
endmodule

// [testbench/dcrl_loader_bench.sv]
// Bench for the reset loader, with the drive model.
// Assumes shortened waits: power-up 200, bus reset 50, busy 100 cycles.
module dcrl_loader_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] LAST = 32'h0000_4C2F;
  logic        clk_i = 1'b0, rst_i = 1'b1, bus_rst_n = 1'b1, half = 1'b1, diag = 1'b0;
  logic        rwc = 1'b1, all_j = 1'b0, multi = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic        ack, xfer, sreq, sdone, rreq, rkind, rdone, rok, dreq, ddone, dsel, busy, brel;
  logic [2:0]  scsi_id, addr = 3'h5;
  logic [7:0]  adr = 8'h00, kinds = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0, rdat, rword, q, n_checks = 0, bad_count = 0;
  logic [31:0] diag_cnt = 0, rd_cnt = 0, c0;
  logic [1:0]  fmt_ok = 2'h1, trk0, pmode, present, fmt_inv, skind, szone;
  int          n;
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (dreq === 1'b1) diag_cnt <= diag_cnt + 1;
    if (rreq === 1'b1) rd_cnt <= rd_cnt + 1;
    if (sreq === 1'b1) kinds[{dsel, skind}] <= 1'b1;
  end
  dcrl_loader #(.PWR_WAIT_CYC(200), .BRST_WAIT_CYC(50), .BUSY_CYC(100)) u_dcrl_loader (
    .clk_i(clk_i), .rst_i(rst_i), .bus_rst_n_i(bus_rst_n), .addr_jmp_i(addr),
    .half_rate_jmp_i(half), .diag_jmp_i(diag), .pcomp_rwc_jmp_i(rwc),
    .pcomp_all_jmp_i(all_j), .data_clk_en_i(1'b1), .multi_sector_i(multi),
    .drv_ready_i(2'h3), .drv_trk0_i(trk0), .seek_done_i(sdone), .seek_err_i(1'b0),
    .rd_done_i(rdone), .rd_ok_i(rok), .rd_data_i(rword), .diag_pass_i(1'b1),
    .diag_done_i(ddone), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .scsi_id_o(scsi_id),
    .xfer_en_o(xfer), .pcomp_mode_o(pmode), .bus_release_o(brel), .drv_present_o(present),
    .fmt_invalid_o(fmt_inv), .busy_o(busy), .drv_sel_o(dsel), .seek_req_o(sreq),
    .seek_kind_o(skind), .seek_zone_o(szone), .rd_req_o(rreq), .rd_kind_o(rkind),
    .diag_req_o(dreq));
  dcrl_drive_model #(.DLY(3), .LAST_BLK(LAST)) u_dcrl_drive_model (
    .clk_i(clk_i), .rst_i(rst_i), .seek_req_i(sreq), .seek_kind_i(skind),
    .seek_zone_i(szone), .rd_req_i(rreq), .rd_kind_i(rkind), .diag_req_i(dreq),
    .drv_sel_i(dsel), .fmt_ok_i(fmt_ok), .seek_done_o(sdone), .rd_done_o(rdone),
    .rd_ok_o(rok), .rd_data_o(rword), .diag_done_o(ddone), .trk0_o(trk0));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int k;
    @(posedge clk_i);
    {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
    q = rdat;
    {cyc, stb, we} <= 3'b000;
    if (k >= 50) bad_count++;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 20000) begin @(posedge clk_i); k++; end
    chk(busy, 0, "busy");
  endtask
  task automatic cmd(input logic [7:0] op, input logic drv, input logic [7:0] exp);
    int k;
    rw(1'b1, 8'h0C, {23'h0, drv, op}, 4'hF);
    k = 0;
    do begin rw(1'b0, 8'h10, 32'h0, 4'hF); k++; end while (q[7:0] !== exp && k < 300);
    chk(q, {24'h0, exp}, "resp");
  endtask
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_idle();
    chk(scsi_id, 5, "scsi_id");
    chk(present, 3, "present");
    chk(fmt_inv, 2, "fmt_invalid");
    chk(kinds, 32'h1F, "seek kinds");
    chk(diag_cnt != 0, 1, "self-test");
    rw(1'b0, 8'h04, 32'h0, 4'hF);
    chk(q[7:0], 32'hB0, "status");
    rw(1'b0, 8'h08, 32'h0, 4'hF);
    chk(q[4:0], 32'h0D, "jumpers");
    rw(1'b0, 8'h14, 32'h0, 4'h1);
    chk(q, LAST, "last block");
    rw(1'b0, 8'h1C, 32'h0, 4'h1);
    chk(q, 32'h0000_0100, "parameters");
    for (int z = 0; z < 4; z++) begin
      rw(1'b0, 8'h18, 32'(z), 4'hF);
      chk(q, 32'h10 + 32'(z), "defect count");
    end
    rw(1'b0, 8'hF0, 32'h0, 4'hF);
    chk(q, 32'h0, "unmapped");
    $display("Test power-up done");
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_i);
      {multi, half} <= 2'(m);
      repeat (10) @(posedge clk_i);
      n = 0;
      repeat (40) begin @(posedge clk_i); n += xfer; end
      chk(32'(n), (m == 1) ? 32'd10 : 32'd20, "xfer count");
    end
    for (int p = 0; p < 4; p++) begin
      @(posedge clk_i);
      {all_j, rwc} <= 2'(p);
      repeat (8) @(posedge clk_i);
      chk(pmode, (p > 1) ? 32'h2 : 32'(p), "precomp");
    end
    $display("Test jumpers done");
    cmd(8'h00, 1'b1, 8'h00);
    c0 = rd_cnt;
    cmd(8'h08, 1'b1, 8'h1C);
    chk(rd_cnt != c0, 1, "recovery read");
    cmd(8'h0A, 1'b1, 8'h1C);
    cmd(8'h0B, 1'b1, 8'h1C);
    cmd(8'h01, 1'b1, 8'h1C);
    fmt_ok <= 2'h3;
    cmd(8'h08, 1'b1, 8'h00);
    chk(fmt_inv, 0, "fmt_invalid");
    $display("Test format lockout done");
    fmt_ok <= 2'h1;
    rw(1'b1, 8'h00, 32'h1, 4'hF);
    repeat (20) @(posedge clk_i);
    bus_rst_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    bus_rst_n <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(busy, 1, "busy on bus reset");
    chk(brel, 1, "bus released");
    wait_idle();
    chk(fmt_inv, 2, "reloaded");
    $display("Test bus reset done");
    diag <= 1'b1;
    bus_rst_n <= 1'b0;
    repeat (2) @(posedge clk_i);
    bus_rst_n <= 1'b1;
    c0 = diag_cnt;
    repeat (4000) @(posedge clk_i);
    chk(diag_cnt - c0 > 1, 1, "self-test loop");
    $display("Test diagnostic done");
    stop_test();
  end
endmodule
